// file: src/crw_ctl_if.sv
/*
 * Control and status bundle between the register file and the record core.
 * Assumes both ends run on the same clock.
 */
interface crw_ctl_if;
    logic        enable;
    logic        raw_mode;
    logic        oc48;
    logic [31:0] base;
    logic [23:0] size;
    logic [23:0] rptr;
    logic [23:0] wptr;
    logic [31:0] loss_total;
    logic [2:0]  events;

    modport reg_mp  (output enable, raw_mode, oc48, base, size, rptr,
                     input  wptr, loss_total, events);
    modport core_mp (input  enable, raw_mode, oc48, base, size, rptr,
                     output wptr, loss_total, events);
endinterface : crw_ctl_if

// file: src/crw_pkg.sv
/*
 * Shared constants, types and helpers of the capture record writer.
 * Assumes a 32-bit APB register bus and a host ring counted in 32-bit words.
 */
package crw_pkg;

    // Register byte offsets
    localparam logic [11:0] CRW_CTRL_OFS = 12'h000;
    localparam logic [11:0] CRW_BASE_OFS = 12'h004;
    localparam logic [11:0] CRW_SIZE_OFS = 12'h008;
    localparam logic [11:0] CRW_RPTR_OFS = 12'h00c;
    localparam logic [11:0] CRW_WPTR_OFS = 12'h010;
    localparam logic [11:0] CRW_LOSS_OFS = 12'h014;
    localparam logic [11:0] CRW_STAT_OFS = 12'h018;
    localparam logic [11:0] CRW_MASK_OFS = 12'h01c;

    // Control bits and event bits
    localparam int CRW_EN_BIT   = 0;
    localparam int CRW_RAW_BIT  = 1;
    localparam int CRW_OC48_BIT = 2;
    localparam int CRW_EV_DROP  = 0;
    localparam int CRW_EV_FULL  = 1;
    localparam int CRW_EV_REC   = 2;

    // Values after reset
    localparam logic [2:0]  CRW_CTRL_RST = 3'h0;
    localparam logic [2:0]  CRW_MASK_RST = 3'h0;
    localparam logic [23:0] CRW_SIZE_RST = 24'h000000;

    // Record header fields
    localparam logic [7:0]  CRW_TYPE_RAW  = 8'h18;
    localparam logic [7:0]  CRW_TYPE_PKT  = 8'h02;
    localparam logic [7:0]  CRW_EXT_RAW   = 8'h05;
    localparam int          CRW_EXT_BIT   = 23;
    localparam int          CRW_MORE_BIT  = 23;
    localparam logic [1:0]  CRW_LAST_SEQ  = 2'h3;
    localparam logic [15:0] CRW_LCTR_MAX  = 16'hffff;

    // Quarter of a 9720-word frame per fragment
    localparam logic [15:0] CRW_FRAG_WORDS = 16'h097e;
    // Worst-case record set: one whole frame plus headers
    localparam logic [23:0] CRW_MIN_FREE   = 24'h002610;

    typedef enum logic [2:0] {
        CRW_IDLE = 3'b000,
        CRW_HDR0 = 3'b001,
        CRW_HDR1 = 3'b011,
        CRW_PAY  = 3'b010,
        CRW_DROP = 3'b110
    } crw_state_t;

    function automatic logic [23:0] crw_used(input logic [23:0] wp, input logic [23:0] rp,
                                             input logic [23:0] size);
        crw_used = (wp >= rp) ? wp - rp : 24'(wp + size - rp);
    endfunction : crw_used

    function automatic logic [23:0] crw_inc(input logic [23:0] ptr, input logic [23:0] size);
        crw_inc = (ptr + 24'h000001 >= size) ? 24'h000000 : ptr + 24'h000001;
    endfunction : crw_inc

endpackage : crw_pkg

// file: src/crw_regs.sv
/*
 * APB register file of the capture record writer, with sticky event status and irq.
 * Assumes an APB master; every transfer completes with no wait state.
 */
module crw_regs
    import crw_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt
    output logic             irq,
    // Core side
    crw_ctl_if.reg_mp        ctl
);

    typedef struct packed {
        logic [2:0]  ctrl;
        logic [31:0] base;
        logic [23:0] size;
        logic [23:0] rptr;
        logic [2:0]  stat;
        logic [2:0]  mask;
        logic [31:0] rdata;
        logic        err;
        logic        irq;
    } crw_reg_st_t;

    localparam crw_reg_st_t REG_RST = '{ctrl: CRW_CTRL_RST, mask: CRW_MASK_RST,
                                        size: CRW_SIZE_RST, default: '0};

    crw_reg_st_t q, d;

    always_comb
    begin
        d = q;
        // Read data is latched in the setup cycle so that prdata comes from a flop
        if (psel && !penable)
        begin
            d.err = 1'b0;
            unique case (paddr)
                CRW_CTRL_OFS: d.rdata = {29'h0, q.ctrl};
                CRW_BASE_OFS: d.rdata = q.base;
                CRW_SIZE_OFS: d.rdata = {8'h0, q.size};
                CRW_RPTR_OFS: d.rdata = {8'h0, q.rptr};
                CRW_WPTR_OFS: d.rdata = {8'h0, ctl.wptr};
                CRW_LOSS_OFS: d.rdata = ctl.loss_total;
                CRW_STAT_OFS: d.rdata = {29'h0, q.stat};
                CRW_MASK_OFS: d.rdata = {29'h0, q.mask};
                default:
                begin
                    d.rdata = 32'h0;
                    d.err   = 1'b1;
                end
            endcase
        end
        if (psel && penable && pwrite)
        begin
            unique case (paddr)
                CRW_CTRL_OFS: d.ctrl = pwdata[2:0];
                CRW_BASE_OFS: d.base = {pwdata[31:2], 2'b00};
                CRW_SIZE_OFS: d.size = pwdata[23:0];
                CRW_RPTR_OFS: d.rptr = pwdata[23:0];
                CRW_STAT_OFS: d.stat = q.stat & ~pwdata[2:0];
                CRW_MASK_OFS: d.mask = pwdata[2:0];
                default: ;
            endcase
        end
        // A new event beats a clear in the same cycle
        d.stat = d.stat | ctl.events;
        d.irq  = |(d.stat & d.mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= REG_RST;
        else
            q <= d;
    end

    assign prdata       = q.rdata;
    assign pready       = 1'b1;
    assign pslverr      = q.err && psel && penable;
    assign irq          = q.irq;
    assign ctl.enable   = q.ctrl[CRW_EN_BIT];
    assign ctl.raw_mode = q.ctrl[CRW_RAW_BIT];
    assign ctl.oc48     = q.ctrl[CRW_OC48_BIT];
    assign ctl.base     = q.base;
    assign ctl.size     = q.size;
    assign ctl.rptr     = q.rptr;

endmodule : crw_regs

// file: src/crw_top.sv
/*
 * Capture record writer: wraps each captured packet or raw frame in records and
 * writes them word by word into a host ring buffer; drops packets while it is full.
 * Assumes the link marks the first word of a packet (the first A1 byte for raw
 * frames) with lnk_sof and the last with lnk_eof, and that a packet never exceeds
 * the worst-case record set held in the package.
 */
// The implementer's own choices: the address map and the APB slave port.
// Behaviour
// [R01] Every captured packet becomes one written record
// [R02] Host drains the ring fast enough
// [R03] Full ring drops new packets until freed
// [R04] Dropped packets counted in record loss field
// [R05] Capture LED goes off while ring full
// [R06] Raw frames use type 24, extension 5
// [R07] Low rate: one record, more 0, seq 0
// [R08] High rate: four records, seq 0-3
// [R09] Record zero starts at first A1 byte
// [R10] Fragments written in order, back to back
module crw_top
    import crw_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Link receive stream
    input  wire logic        lnk_valid,
    input  wire logic        lnk_sof,
    input  wire logic        lnk_eof,
    input  wire logic [31:0] lnk_data,
    output logic             lnk_ready,
    // Host memory write port
    output logic             mem_valid,
    output logic      [31:0] mem_addr,
    output logic      [31:0] mem_data,
    input  wire logic        mem_ready,
    // Indicators
    output logic             capture_led,
    output logic             irq
);

    typedef struct packed {
        crw_state_t  st;
        logic        raw;
        logic        oc48;
        logic [1:0]  seq;
        logic [15:0] wcnt;
        logic [15:0] lctr;
        logic [31:0] loss_tot;
        logic [23:0] wptr;
        logic        ov;
        logic [31:0] oaddr;
        logic [31:0] odata;
        logic        full_prev;
        logic        led;
        logic [2:0]  ev;
    } crw_core_st_t;

    // Full counts as already seen at reset, so a zero-sized ring raises no false full event
    localparam crw_core_st_t CORE_RST = '{st: CRW_IDLE, full_prev: 1'b1, default: '0};

    crw_ctl_if ctl ();

    crw_regs u_regs (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .irq     (irq),
        .ctl     (ctl)
    );

    crw_core_st_t q, d;
    logic         adv;
    logic         full;
    logic         emit;
    logic [31:0]  word;
    logic         frag_end;
    logic [23:0]  used;

    // Output register advances when empty or taken by memory
    assign adv  = !q.ov || mem_ready;
    assign used = crw_used(q.wptr, ctl.rptr, ctl.size);
    // Full means less room than the largest record set; a zero-sized ring counts as full
    assign full = ({1'b0, ctl.size} <= {1'b0, used} + {1'b0, CRW_MIN_FREE});
    assign frag_end = q.raw && q.oc48 && (q.seq != CRW_LAST_SEQ)
                      && (q.wcnt == CRW_FRAG_WORDS - 16'h0001);

    always_comb
    begin
        lnk_ready = 1'b0;
        unique case (q.st)
            CRW_IDLE: lnk_ready = !ctl.enable || !lnk_sof || full; // R03 R09
            CRW_PAY:  lnk_ready = adv;
            CRW_DROP: lnk_ready = 1'b1; // R03
            default:  lnk_ready = 1'b0;
        endcase
    end

    always_comb
    begin
        d    = q;
        emit = 1'b0;
        word = 32'h0;
        d.ev = 3'h0;
        if (adv)
            d.ov = 1'b0;
        unique case (q.st)
            CRW_IDLE:
            begin
                if (lnk_valid && lnk_sof && ctl.enable)
                begin
                    d.raw  = ctl.raw_mode;
                    d.oc48 = ctl.oc48;
                    d.seq  = 2'h0;
                    if (full)
                    begin
                        // Whole packet is discarded, only its count survives
                        if (q.lctr != CRW_LCTR_MAX)
                            d.lctr = q.lctr + 16'h0001; // R04
                        d.loss_tot = q.loss_tot + 32'h00000001;
                        d.ev[CRW_EV_DROP] = 1'b1;
                        if (!lnk_eof)
                            d.st = CRW_DROP; // R03
                    end
                    else
                        d.st = CRW_HDR0; // R01 R09
                end
            end
            CRW_HDR0:
            begin
                if (adv)
                begin
                    emit = 1'b1;
                    word = {(q.raw ? CRW_TYPE_RAW : CRW_TYPE_PKT), 8'h00, q.lctr}; // R04 R06
                    word[CRW_EXT_BIT] = q.raw;
                    d.lctr = 16'h0000;
                    d.wcnt = 16'h0000;
                    d.st   = q.raw ? CRW_HDR1 : CRW_PAY;
                end
            end
            CRW_HDR1:
            begin
                if (adv)
                begin
                    emit = 1'b1;
                    word = {CRW_EXT_RAW, 8'h00, 14'h0000, q.seq}; // R06
                    // More fragments follow on all but the last quarter
                    word[CRW_MORE_BIT] = q.oc48 && (q.seq != CRW_LAST_SEQ); // R07 R08
                    d.st = CRW_PAY;
                end
            end
            CRW_PAY:
            begin
                if (adv && lnk_valid)
                begin
                    emit   = 1'b1;
                    word   = lnk_data;
                    d.wcnt = q.wcnt + 16'h0001;
                    if (lnk_eof)
                    begin
                        d.st = CRW_IDLE;
                        d.ev[CRW_EV_REC] = 1'b1;
                    end
                    else if (frag_end)
                    begin
                        d.st  = CRW_HDR0; // R08 R10
                        d.seq = q.seq + 2'h1;
                        d.ev[CRW_EV_REC] = 1'b1;
                    end
                end
            end
            CRW_DROP:
            begin
                if (lnk_valid && lnk_eof)
                    d.st = CRW_IDLE;
            end
            default: d.st = CRW_IDLE;
        endcase
        if (emit)
        begin
            d.ov    = 1'b1;
            d.odata = word;
            d.oaddr = ctl.base + {6'h00, q.wptr, 2'b00};
            d.wptr  = crw_inc(q.wptr, ctl.size);
        end
        d.full_prev = full;
        d.ev[CRW_EV_FULL] = full && !q.full_prev;
        // Dark LED tells the operator records are being lost
        d.led = ctl.enable && !full; // R05
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= CORE_RST;
        else
            q <= d;
    end

    assign mem_valid      = q.ov;
    assign mem_addr       = q.oaddr;
    assign mem_data       = q.odata;
    assign capture_led    = q.led;
    assign ctl.wptr       = q.wptr;
    assign ctl.loss_total = q.loss_tot;
    assign ctl.events     = q.ev;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    rec_start_a: assert property ((q.st == CRW_HDR0) && adv |=> mem_valid && (q.st != CRW_HDR0)) // R01
        else $error("record header not written");
    drop_full_a: assert property ((q.st == CRW_IDLE) && lnk_valid && lnk_sof && ctl.enable && full // R03
                                  |-> lnk_ready ##1 (q.st != CRW_HDR0))
        else $error("packet taken while ring full");
    loss_count_a: assert property ((q.st == CRW_IDLE) && lnk_valid && lnk_sof && ctl.enable && full // R04
                                   |=> (q.lctr != 16'h0000) && (q.loss_tot == $past(q.loss_tot) + 32'h1))
        else $error("dropped packet not counted");
    led_off_a: assert property (full |=> !capture_led) // R05
        else $error("capture LED lit while ring full");
    raw_type_a: assert property ((q.st == CRW_HDR0) && adv && q.raw // R06
                                 |=> (mem_data[31:24] == CRW_TYPE_RAW) && mem_data[CRW_EXT_BIT]
                                     && (q.st == CRW_HDR1))
        else $error("raw record type wrong");
    ext_type_a: assert property ((q.st == CRW_HDR1) && adv |=> mem_data[31:24] == CRW_EXT_RAW) // R06
        else $error("extension header type wrong");
    single_rec_a: assert property ((q.st == CRW_HDR1) && adv && !q.oc48 // R07
                                   |=> !mem_data[CRW_MORE_BIT] && (mem_data[15:0] == 16'h0000))
        else $error("low-rate record not single");
    frag_bits_a: assert property ((q.st == CRW_HDR1) && adv && q.oc48 // R08
                                  |=> (mem_data[CRW_MORE_BIT] == ($past(q.seq) != CRW_LAST_SEQ))
                                      && (mem_data[1:0] == $past(q.seq)))
        else $error("fragment flag or sequence wrong");
    sof_align_a: assert property ((q.st == CRW_IDLE) && (d.st == CRW_HDR0) // R09
                                  |-> lnk_sof && !lnk_ready && (d.seq == 2'h0))
        else $error("record zero not aligned to frame start");
    frag_order_a: assert property ((q.st == CRW_PAY) && (d.st == CRW_HDR0) // R10
                                   |=> (q.seq == $past(q.seq) + 2'h1) && (q.st == CRW_HDR0))
        else $error("fragment order broken");
    mem_hold_a: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_data) && $stable(mem_addr))
        else $error("memory write changed while stalled");

    // Drops leave the ring untouched; with room again the next packet is written
    drop_quiet_a: assert property ((q.st == CRW_DROP) |-> lnk_ready ##1 $stable(q.wptr)) // R03
        else $error("ring written while dropping");
    write_resume_a: assert property ((q.st == CRW_IDLE) && lnk_valid && lnk_sof && ctl.enable && !full // R03
                                     |=> (q.st == CRW_HDR0) && (q.seq == 2'h0))
        else $error("packet dropped although ring has room");
    loss_clear_a: assert property ((q.st == CRW_HDR0) && adv // R04
                                   |=> (mem_data[15:0] == $past(q.lctr)) && (q.lctr == 16'h0000))
        else $error("loss field not carried or not cleared");
    led_on_a: assert property (ctl.enable && !full |=> capture_led) // R05
        else $error("capture LED dark while ring has room");

    // Record contents
    pkt_type_a: assert property ((q.st == CRW_HDR0) && adv && !q.raw // R01
                                 |=> (mem_data[31:24] == CRW_TYPE_PKT) && !mem_data[CRW_EXT_BIT]
                                     && (q.st == CRW_PAY))
        else $error("packet record header wrong");
    pay_copy_a: assert property ((q.st == CRW_PAY) && adv && lnk_valid // R01
                                 |=> mem_valid && (mem_data == $past(lnk_data)))
        else $error("payload word altered");
    rec_event_a: assert property ((q.st == CRW_PAY) && (d.st == CRW_IDLE) |=> q.ev[CRW_EV_REC]) // R01
        else $error("record completion not flagged");
    seq_low_a: assert property ((q.st == CRW_HDR1) && !q.oc48 |-> (q.seq == 2'h0)) // R07
        else $error("low-rate record has nonzero sequence");

    // Fragmenting and ordering
    frag_len_a: assert property ((q.st == CRW_PAY) && (d.st == CRW_HDR0) // R08
                                 |-> lnk_valid && !lnk_eof && (q.wcnt == CRW_FRAG_WORDS - 16'h0001))
        else $error("fragment closed at wrong length");
    last_frag_a: assert property ((q.st == CRW_PAY) && q.oc48 && (q.seq == CRW_LAST_SEQ) // R08
                                  |-> (d.st != CRW_HDR0))
        else $error("fifth fragment started");
    seq_origin_a: assert property ((q.st == CRW_HDR0) && (q.seq == 2'h0) // R09
                                   |-> ($past(q.st) == CRW_IDLE) || ($past(q.st) == CRW_HDR0))
        else $error("record zero not opened at frame start");
    addr_step_a: assert property (mem_valid && mem_ready ##1 mem_valid // R10
                                  |-> (mem_addr == $past(mem_addr) + 32'h00000004) || (mem_addr == ctl.base))
        else $error("record words not back to back in the ring");

    drop_c: cover property ((q.st == CRW_IDLE) && lnk_valid && lnk_sof && ctl.enable && full);
    last_frag_c: cover property ((q.st == CRW_HDR1) && adv && (q.seq == CRW_LAST_SEQ));
    single_c: cover property ((q.st == CRW_HDR1) && adv && !q.oc48);
    resume_c: cover property (q.full_prev && !full);
    frag_next_c: cover property ((q.st == CRW_PAY) && (d.st == CRW_HDR0));

endmodule : crw_top

// file: verification/crw_host_mem.sv
/*
 * Host memory model for the capture record writer: the ring that software drains.
 * Assumes one word per transfer; the word is taken at an edge with valid and ready.
 */
module crw_host_mem
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Write port from the device
    input  wire logic        mem_valid,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_data,
    output logic             mem_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] ring_q [logic [31:0]];
    int          seed;

    initial seed = 32'h308a;

    // Random stalls keep the device's hold-while-stalled path busy
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            mem_ready <= 1'b0;
        else
        begin
            mem_ready <= ($random(seed) & 3) != 0;
            if (mem_valid === 1'b1 && mem_ready === 1'b1)
                ring_q[mem_addr] = mem_data;
        end
endmodule : crw_host_mem

// file: verification/tb_crw_top.sv
/*
 * Self-checking bench of the capture record writer: registers, packet and raw
 * frame capture, drops on a full ring, loss reporting, LED and interrupt.
 * Assumes the host memory model answers the write port with random stalls.
 */
module tb_crw_top
    import crw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        lnk_valid, lnk_sof, lnk_eof, lnk_ready, mem_valid, mem_ready, capture_led, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, lnk_data, mem_addr, mem_data, base, rd;
    logic [23:0] size, wp, rp;
    logic [15:0] loss;
    logic [63:0] exp_q [$];
    int          miscompares, compares, seed;

    crw_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                   .lnk_valid(lnk_valid), .lnk_sof(lnk_sof), .lnk_eof(lnk_eof), .lnk_data(lnk_data),
                   .lnk_ready(lnk_ready), .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_data(mem_data),
                   .mem_ready(mem_ready), .capture_led(capture_led), .irq(irq));

    crw_host_mem host_u (.pclk(pclk), .presetn(presetn), .mem_valid(mem_valid), .mem_addr(mem_addr),
                         .mem_data(mem_data), .mem_ready(mem_ready));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("Compares %0d, miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 1000);
        if (pready !== 1'b1)
            miscompares++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Room test as software sees it: full when free words cannot hold a worst-case record set
    function automatic bit ring_full();
        int u;
        u = (wp >= rp) ? int'(wp) - int'(rp) : int'(wp) + int'(size) - int'(rp);
        return int'(size) <= u + 9744;
    endfunction : ring_full

    function automatic void push(input logic [31:0] d);
        exp_q.push_back({base + (32'(wp) << 2), d});
        wp = (wp + 24'h000001 >= size) ? 24'h000000 : wp + 24'h000001;
    endfunction : push

    task automatic send(input bit raw, input bit oc48, input int n);
        int          s;
        bit          drop;
        logic [31:0] d;
        drop = ring_full();
        if (drop && loss != 16'hffff)
            loss = loss + 16'h0001;
        for (int i = 0; i < n; i++)
        begin
            s = (oc48 && raw) ? i / 2430 : 0;
            if (!drop && (i == 0 || (oc48 && raw && i % 2430 == 0 && s < 4)))
            begin
                push({raw ? 8'h18 : 8'h02, raw, 7'h00, s == 0 ? loss : 16'h0000});
                if (raw)
                    push({8'h05, oc48 && s < 3, 21'h000000, 2'(s)});
                loss = (s == 0) ? 16'h0000 : loss;
            end
            d = $random(seed);
            lnk_valid <= 1'b1;
            lnk_sof   <= (i == 0);
            lnk_eof   <= (i == n - 1);
            lnk_data  <= d;
            if (!drop)
                push(d);
            s = 0;
            do
            begin
                @(posedge pclk);
                s++;
            end
            while (lnk_ready !== 1'b1 && s < 1000);
            if (lnk_ready !== 1'b1)
                miscompares++;
        end
        lnk_valid <= 1'b0;
        @(posedge pclk);
    endtask : send

    task automatic wait_drain();
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < 50000)
        begin
            @(posedge pclk);
            k++;
        end
        if (exp_q.size() != 0)
            miscompares++;
        repeat (4) @(posedge pclk);
    endtask : wait_drain

    // Every word written to the host must be the next one expected, at the next ring address
    always @(posedge pclk)
        if (mem_valid === 1'b1 && mem_ready === 1'b1)
            chk({mem_addr, mem_data}, exp_q.size() != 0 ? exp_q.pop_front() : ~{mem_addr, mem_data});

    initial
    begin
        repeat (90000) @(posedge pclk);
        miscompares++;
        test_done();
    end

    initial
    begin
        seed = 32'h308a;
        {presetn, psel, penable, pwrite, lnk_valid, lnk_sof, lnk_eof} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        lnk_data = 32'h00000000;
        {miscompares, compares} = 0;
        {wp, rp, size, loss, base} = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a < 36; a += 4)
        begin
            apb(1'b0, 12'(a), 32'h00000000);
            chk({31'h0, err, rd}, {31'h0, 1'(a == 32), 32'h00000000});
        end
        base = $random(seed) & 32'hfff00000;
        size = 24'h002614;
        apb(1'b1, 12'h004, base);
        apb(1'b1, 12'h008, 32'(size));
        apb(1'b1, 12'h000, 32'h00000001);
        send(1'b0, 1'b0, 2);
        wait_drain();
        chk(capture_led, 1'b1);
        send(1'b0, 1'b0, 2);
        wait_drain();
        chk(capture_led, 1'b0);
        send(1'b0, 1'b0, 3);
        send(1'b0, 1'b0, 1);
        wait_drain();
        apb(1'b1, 12'h014, 32'hffffffff);
        apb(1'b0, 12'h014, 32'h00000000);
        chk(rd, 32'h00000002);
        chk(irq, 1'b0);
        apb(1'b0, 12'h018, 32'h00000000);
        chk(rd & 32'h00000003, 32'h00000003);
        apb(1'b1, 12'h01c, 32'h00000001);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b1, 12'h018, 32'h00000007);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        rp = wp;
        apb(1'b1, 12'h00c, 32'(rp));
        repeat (4) @(posedge pclk);
        chk(capture_led, 1'b1);
        apb(1'b1, 12'h000, 32'h00000003);
        send(1'b1, 1'b0, 4 + ($random(seed) & 3));
        wait_drain();
        size = 24'h004000;
        rp = wp;
        apb(1'b1, 12'h008, 32'(size));
        apb(1'b1, 12'h00c, 32'(rp));
        apb(1'b1, 12'h000, 32'h00000007);
        send(1'b1, 1'b1, 9720);
        wait_drain();
        for (int p = 0; p < 8; p++)
        begin
            bit raw_pick;
            raw_pick = 1'($random(seed));
            rp = wp;
            apb(1'b1, 12'h00c, 32'(rp));
            apb(1'b1, 12'h000, {29'h0, 1'b0, raw_pick, 1'b1});
            send(raw_pick, 1'b0, 1 + ($random(seed) & 15));
            wait_drain();
        end
        test_done();
    end
endmodule : tb_crw_top
